// File: core/btce_exec.sv
// Execution core for AND-immediate, set-bit, bit-test skips and call.
// Assumes one instruction per enabled clock from the fetch stage; fetch
// follows pc_o. Register file is internal; accumulator is exposed.
`timescale 1ns/10ps
module btce_exec #(
  parameter int STACK_DEPTH = btce_pkg::STACK_D
) (
  input  wire logic                            clk_i,
  input  wire logic                            nrst_i,
  input  wire logic                            ce_i,
  input  wire logic [btce_pkg::INSN_W-1:0]     insn_i,
  input  wire logic [btce_pkg::DATA_W-1:0]     pc_high_buffer_i,
  output logic      [btce_pkg::PC_W-1:0]       pc_o,
  output logic      [btce_pkg::DATA_W-1:0]     accumulator_o,
  output logic                                 zero_o,
  output logic      [btce_pkg::SP_W-1:0]       sp_o,
  output logic      [btce_pkg::PC_W-1:0]       stack_top_o,
  output logic                                 discard_o
);
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {BTCE_RUN, BTCE_SKIP, BTCE_CALL2} btce_state_t;

  btce_state_t                   state_reg;
  btce_state_t                   state_next;
  logic [btce_pkg::PC_W-1:0]     pc_reg;
  logic [btce_pkg::PC_W-1:0]     pc_next;
  logic [btce_pkg::DATA_W-1:0]   acc_reg;
  logic                          zero_reg;
  logic [btce_pkg::SP_W-1:0]     sp_reg;
  logic [btce_pkg::PC_W-1:0]     stack_reg [STACK_DEPTH];
  logic [btce_pkg::PC_W-1:0]     top_reg;

  btce_rf_if rf ();

  btce_regfile #(
    .DEPTH (1 << btce_pkg::ADDR_W)
  ) u_rf (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .ce_i   (ce_i),
    .rf     (rf)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [btce_pkg::DATA_W-1:0] btce_bit_mask(
    input logic [btce_pkg::BIT_W-1:0] idx
  );
    btce_bit_mask = btce_pkg::ONE_B << idx;
  endfunction

  // Opcode compare shared by every decode line
  function automatic logic btce_op_hit(
    input logic [btce_pkg::OPC_W-1:0] field,
    input btce_pkg::btce_opc_t        code
  );
    btce_op_hit = (field == code);
  endfunction

  // ---------------------------------------------------------------
  // Field extraction
  // ---------------------------------------------------------------
  wire                        live     = (state_reg == BTCE_RUN);
  wire [btce_pkg::OPC_W-1:0]  opc_fld  = insn_i[btce_pkg::OPC_LSB +: btce_pkg::OPC_W];
  wire [btce_pkg::DATA_W-1:0] imm      = insn_i[btce_pkg::DATA_W-1:0];
  wire [btce_pkg::ADDR_W-1:0] reg_adr  = insn_i[btce_pkg::ADDR_W-1:0];
  wire [btce_pkg::BIT_W-1:0]  bit_idx  = insn_i[btce_pkg::BIT_LSB +: btce_pkg::BIT_W];
  wire [btce_pkg::DATA_W-1:0] mask     = btce_bit_mask(bit_idx);
  wire                        bit_one  = |(rf.rdata & mask);

  // ---------------------------------------------------------------
  // Opcode decode
  // ---------------------------------------------------------------
  // Unlisted codes match nothing and so fall through as a no-op
  wire                        op_andi  = btce_op_hit(opc_fld, btce_pkg::OPC_ANDI);
  wire                        op_setb  = btce_op_hit(opc_fld, btce_pkg::OPC_SETB);
  wire                        op_skpc  = btce_op_hit(opc_fld, btce_pkg::OPC_SKPC);
  wire                        op_skps  = btce_op_hit(opc_fld, btce_pkg::OPC_SKPS);
  wire                        op_call  = btce_op_hit(opc_fld, btce_pkg::OPC_CALL);

  // Gating by live keeps a discarded word from acting
  wire                        is_andi  = live && op_andi;
  wire                        is_setb  = live && op_setb;
  wire                        is_call  = live && op_call;
  wire                        skip_clr = live && op_skpc && !bit_one;
  wire                        skip_set = live && op_skps && bit_one;
  wire                        skip_tk  = skip_clr || skip_set;

  // ---------------------------------------------------------------
  // Datapath
  // ---------------------------------------------------------------
  wire [btce_pkg::DATA_W-1:0] and_res  = acc_reg & imm;
  wire                        and_zero = (and_res == btce_pkg::ZERO_B);
  wire [btce_pkg::PC_W-1:0]   pc_inc   = pc_reg + btce_pkg::PC_ONE;
  wire [btce_pkg::PC_W-1:0]   call_tgt = {pc_high_buffer_i[btce_pkg::PCH_W-1:0], imm};
  wire [btce_pkg::SP_W-1:0]   sp_inc   = sp_reg + btce_pkg::SP_ONE;
  // Enables fold in ce_i so a frozen clock moves nothing
  wire                        acc_en   = ce_i && is_andi;
  wire                        push_en  = ce_i && is_call;

  // Set-bit is a read-modify-write of one byte within a single cycle
  assign rf.raddr = reg_adr;
  assign rf.we    = is_setb;
  assign rf.waddr = reg_adr;
  assign rf.wdata = rf.rdata | mask;

  // ---------------------------------------------------------------
  // Sequencing
  // ---------------------------------------------------------------
  always_comb begin
    state_next = BTCE_RUN;
    pc_next    = pc_inc;
    unique case (state_reg)
      BTCE_RUN: begin
        if (skip_tk) begin
          state_next = BTCE_SKIP;
        end else if (is_call) begin
          state_next = BTCE_CALL2;
          pc_next    = call_tgt;
        end
      end
      // Discarded word: PC still advances, nothing else moves
      BTCE_SKIP: begin
        state_next = BTCE_RUN;
      end
      // The target word shows during the filler cycle; PC holds so that
      // it runs next instead of being lost
      BTCE_CALL2: begin
        state_next = BTCE_RUN;
        pc_next    = pc_reg;
      end
      // Fourth state code is unreachable; recover to run
      default: begin
        state_next = BTCE_RUN;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state_reg <= BTCE_RUN;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pc_reg <= btce_pkg::PC_RST;
    end else if (ce_i) begin
      pc_reg <= pc_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      acc_reg <= btce_pkg::ACC_RST;
    end else if (acc_en) begin
      acc_reg <= and_res;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      zero_reg <= 1'b0;
    end else if (acc_en) begin
      zero_reg <= and_zero;
    end
  end

  // ---------------------------------------------------------------
  // Return stack
  // ---------------------------------------------------------------
  // Stack wraps silently on overflow; no depth check in hardware
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sp_reg <= btce_pkg::SP_RST;
    end else if (push_en) begin
      sp_reg <= sp_inc;
    end
  end

  // Array kept as plain storage without reset; the copy below is visible
  always_ff @(posedge clk_i) begin
    if (nrst_i && push_en) begin
      stack_reg[sp_reg] <= pc_inc;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      top_reg <= btce_pkg::PC_RST;
    end else if (push_en) begin
      top_reg <= pc_inc;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign pc_o          = pc_reg;
  assign accumulator_o = acc_reg;
  assign zero_o        = zero_reg;
  assign sp_o          = sp_reg;
  assign stack_top_o   = top_reg;
  assign discard_o     = !live;
endmodule

// File: core/btce_pkg.sv
// Package for the bit-test/call execution block: widths, opcodes, reset values.
// Assumes a 14-bit instruction word supplied by the fetch stage each cycle.
package btce_pkg;
  localparam int DATA_W    = 8;
  localparam int ADDR_W    = 6;
  localparam int BIT_W     = 3;
  localparam int PC_W      = 10;
  localparam int SP_W      = 3;
  localparam int OPC_W     = 3;
  localparam int INSN_W    = 14;
  localparam int STACK_D   = 8;
  // Field positions within the instruction word
  localparam int OPC_LSB   = 11;
  localparam int BIT_LSB   = 6;
  localparam int PCH_W     = 2;
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [PC_W-1:0]   PC_RST  = 10'h000;
  localparam logic [PC_W-1:0]   PC_ONE  = 10'h001;
  localparam logic [SP_W-1:0]   SP_RST  = 3'h0;
  localparam logic [SP_W-1:0]   SP_ONE  = 3'h1;
  localparam logic [DATA_W-1:0] ZERO_B  = 8'h00;
  localparam logic [DATA_W-1:0] ONE_B   = 8'h01;
  typedef enum logic [OPC_W-1:0] {
    OPC_NOP   = 3'h0,
    OPC_ANDI  = 3'h1,
    OPC_SETB  = 3'h2,
    OPC_SKPC  = 3'h3,
    OPC_SKPS  = 3'h4,
    OPC_CALL  = 3'h5
  } btce_opc_t;
endpackage

// File: core/btce_rf_if.sv
// Interface carrying register-file accesses between executor and file.
// Assumes one read port and one write port, same clock.
`timescale 1ns/10ps
interface btce_rf_if;
  logic [btce_pkg::ADDR_W-1:0] raddr;
  logic [btce_pkg::DATA_W-1:0] rdata;
  logic                        we;
  logic [btce_pkg::ADDR_W-1:0] waddr;
  logic [btce_pkg::DATA_W-1:0] wdata;
  modport exec (output raddr, input rdata, output we, output waddr, output wdata);
  modport file (input raddr, output rdata, input we, input waddr, input wdata);
endinterface

// File: core/btce_regfile.sv
// Data register file, 64 bytes, combinational read, clocked write.
// Assumes the executor drives one write at most per cycle.
`timescale 1ns/10ps
module btce_regfile #(
  parameter int DEPTH = 64
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic ce_i,
  btce_rf_if.file   rf
);
  logic [btce_pkg::DATA_W-1:0] mem_reg [DEPTH];

  assign rf.rdata = mem_reg[rf.raddr];

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= btce_pkg::ZERO_B;
      end
    end else if (ce_i && rf.we) begin
      mem_reg[rf.waddr] <= rf.wdata;
    end
  end
endmodule

// File: tb/btce_prog_mem.sv
// Program memory model: returns the word at the fetch address.
// Assumes the bench loads the words while the executor is in reset.
`timescale 1ns/10ps
module btce_prog_mem (
  input  wire logic [9:0]  addr_i,
  output logic      [13:0] word_o
);
  logic [13:0] mem [1024];
  // Read combinationally at addr_i, so a skipped word is still presented
  assign word_o = mem[addr_i];
endmodule

// File: tb/btce_exec_assertions.sv
// Checker for the executor, watching only its ports.
// Assumes the opcode encoding and field positions of the package.
`timescale 1ns/10ps
module btce_exec_assertions #(
  parameter int STACK_DEPTH = btce_pkg::STACK_D
) (
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic        ce_i,
  input wire logic [13:0] insn_i,
  input wire logic [7:0]  pc_high_buffer_i,
  input wire logic [9:0]  pc_o,
  input wire logic [7:0]  accumulator_o,
  input wire logic        zero_o,
  input wire logic [2:0]  sp_o,
  input wire logic [9:0]  stack_top_o,
  input wire logic        discard_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  wire [2:0] opc = insn_i[13:11];
  wire [7:0] imm = insn_i[7:0];
  wire [1:0] pch = pc_high_buffer_i[1:0];
  wire       go  = ce_i && !discard_o;
  wire       gc  = go && opc == 3'h5;
  // Marks that the pending discarded word is a call filler, not a skip
  logic call_fill_reg;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      call_fill_reg <= 1'b0;
    end else if (gc) begin
      call_fill_reg <= 1'b1;
    end else if (discard_o && ce_i) begin
      call_fill_reg <= 1'b0;
    end
  end
  AST_ANDI: assert property (
    go && opc == 3'h1 |=> accumulator_o == ($past(accumulator_o) & $past(imm))
    && zero_o == (accumulator_o == 8'h00)) else $error("and result wrong");
  AST_SETB_FLAGS: assert property (
    go && opc == 3'h2 |=> $stable(zero_o) && $stable(accumulator_o))
    else $error("set bit touched flags");
  AST_SKIP_ADV: assert property (
    go && (opc == 3'h3 || opc == 3'h4) |=> pc_o == $past(pc_o) + 10'h001)
    else $error("bit test pc wrong");
  AST_DISC_ONE: assert property (discard_o && ce_i |=> !discard_o)
    else $error("discard longer than one cycle");
  AST_DISC_QUIET: assert property (
    discard_o && ce_i |=> $stable(sp_o) && $stable(zero_o) && $stable(accumulator_o)
    && $stable(stack_top_o) && pc_o == $past(pc_o) + {9'h000, !$past(call_fill_reg)})
    else $error("discard effect");
  AST_CALL_PC: assert property (
    gc |=> discard_o && pc_o == {$past(pch), $past(imm)}) else $error("call target wrong");
  AST_CALL_PUSH: assert property (
    gc |=> stack_top_o == $past(pc_o) + 10'h001 && sp_o == $past(sp_o) + 3'h1)
    else $error("call push wrong");
  AST_ONE_CYCLE: assert property (go && opc < 3'h3 |=> !discard_o)
    else $error("single cycle op stalled");
  AST_FREEZE: assert property (
    !ce_i |=> $stable(pc_o) && $stable(sp_o) && $stable(discard_o))
    else $error("state moved while disabled");
  cover property (go && opc == 3'h4 ##1 discard_o);
  cover property (go && opc == 3'h3 ##1 discard_o);
  cover property (gc);
  cover property (!ce_i ##1 !ce_i);
endmodule
bind btce_exec btce_exec_assertions #(.STACK_DEPTH(STACK_DEPTH)) u_chk (
  .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .insn_i(insn_i),
  .pc_high_buffer_i(pc_high_buffer_i), .pc_o(pc_o), .accumulator_o(accumulator_o),
  .zero_o(zero_o), .sp_o(sp_o), .stack_top_o(stack_top_o), .discard_o(discard_o));

// File: tb/test_bit_test_call_exec.sv
// Self-checking bench: a fixed nine-word program with random operands through the executor.
// Assumes program memory follows pc_o and reset clears the register file.
`timescale 1ns/10ps
module test_bit_test_call_exec;
  logic clk_i = 1'b0, nrst_i = 1'b0, ce_i = 1'b1, g, zero, disc;
  logic [7:0] pchb = 8'h00, acc, adr;
  logic [13:0] insn;
  logic [9:0] pc, top;
  logic [2:0] sp, b;
  logic [5:0] r;
  int miscompares = 0, cmp_count = 0, cycles = 0;
  integer seed = 32'hf1d1d0a0;
  always #12.5 clk_i = ~clk_i;
  btce_exec u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .insn_i(insn),
    .pc_high_buffer_i(pchb), .pc_o(pc), .accumulator_o(acc), .zero_o(zero), .sp_o(sp),
    .stack_top_o(top), .discard_o(disc));
  btce_prog_mem u_mem (.addr_i(pc), .word_o(insn));
  function automatic logic [13:0] mk(input logic [2:0] op, input logic [10:0] f);
    return {op, f};
  endfunction
  function automatic logic [9:0] tgt(input logic [7:0] h, input logic [7:0] a);
    return {h[1:0], a};
  endfunction
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Random enable gaps; returns after one executing edge
  task automatic step(input logic [9:0] epc, input logic ed);
    do begin
      @(posedge clk_i);
      g = ce_i;
      ce_i <= ($random(seed) % 4) != 0;
    end while (g !== 1'b1);
    @(negedge clk_i);
    check("pc", pc, epc);
    check("discard", {9'h000, disc}, {9'h000, ed});
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  initial begin
    foreach (u_mem.mem[k]) u_mem.mem[k] = 14'h0000;
    for (int i = 0; i < 24; i++) begin
      @(posedge clk_i);
      nrst_i <= 1'b0;
      pchb <= 8'($random(seed));
      @(negedge clk_i);
      r = (i == 0) ? 6'h3f : 6'($random(seed));
      b = (i == 0) ? 3'h7 : 3'($random(seed));
      adr = 8'($random(seed));
      u_mem.mem[0] = mk(3'h2, {2'h0, b, r});
      u_mem.mem[1] = mk(3'h3, {2'h0, b, r});
      u_mem.mem[2] = mk(3'h4, {2'h0, b, r});
      u_mem.mem[3] = mk(3'h5, 11'h055);
      u_mem.mem[4] = mk(3'h3, {2'h0, b + 3'h1, r});
      u_mem.mem[5] = mk(3'h1, 11'h0ff);
      u_mem.mem[6] = mk(3'h1, {3'h0, 8'($random(seed))});
      u_mem.mem[7] = mk(3'h4, {2'h0, b + 3'h1, r});
      u_mem.mem[8] = mk(3'h5, {3'h0, adr});
      repeat (4) @(posedge clk_i);
      nrst_i <= 1'b1;
      for (int k = 1; k < 9; k++) begin
        step(10'(k), (k == 3) || (k == 5));
        if (k == 4) check("sp", {7'h00, sp}, 10'h000);
        if (k == 6) check("zero", {9'h000, zero}, 10'h000);
      end
      step(tgt(pchb, adr), 1'b1);
      check("acc", {2'h0, acc}, 10'h000);
      check("zero", {9'h000, zero}, 10'h001);
      check("sp", {7'h00, sp}, 10'h001);
      check("top", top, 10'h009);
      step(tgt(pchb, adr), 1'b0);
      $display("test %0d done", i);
    end
    give_verdict();
  end
endmodule
